// ### hw/ptt_regs.vh
// register map, field positions and timing counts for the three-timer block
// assumes a 32-bit plain register port, word addresses in units of 4 bytes
`ifndef PTT_REGS_VH
`define PTT_REGS_VH
`define PTT_NUM_TIMERS 3
// per-timer block: base 0x10 * (timer+1), four registers inside
`define PTT_TMR_STRIDE 8'h10
`define PTT_OFS_CTL 8'h00
`define PTT_OFS_CNT 8'h04
`define PTT_OFS_PRD 8'h08
`define PTT_OFS_WID 8'h0c
`define PTT_ADDR_STAT 8'h00
// control word fields
`define PTT_CTL_MODE_LO 0
`define PTT_CTL_PULSE 2
`define PTT_CTL_PERIOD_COUNT_SELECT 3
`define PTT_CTL_INTERRUPT_ENABLE 4
`define PTT_CTL_MASK 32'h0000001f
// mode encodings
`define PTT_MODE_OFF 2'h0
`define PTT_MODE_PWM 2'h1
`define PTT_MODE_CAP 2'h2
`define PTT_MODE_EVT 2'h3
// global status fields, timer n at bit offset n
`define PTT_STAT_IRQ_LO 0
`define PTT_STAT_OVF_LO 4
`define PTT_STAT_ON_LO 8
`define PTT_STAT_OFF_LO 12
`define PTT_START_DELAY 3
`define PTT_VAL_MASK 32'h7fffffff
`define PTT_ALL_ONES 32'hffffffff
`endif

// ### hw/ptt_timer_trio.v
// three independent 32-bit peripheral timers with a shared status register
// assumes signals arrive from a routing unit as asynchronous levels
`timescale 1ns/1ps
`default_nettype none
`include "ptt_regs.vh"

module ptt_timer_trio #(
    parameter NT = `PTT_NUM_TIMERS
) (
    input wire clk_i, // peripheral clock, 100 MHz
    input wire rst_n_i, // async reset, active low
    input wire [7:0] addr_i, // register byte address
    input wire [31:0] wdata_i, // write data
    input wire wr_i, // write strobe
    input wire rd_i, // read strobe
    output reg [31:0] rdata_o, // read data, cycle after strobe
    input wire [NT-1:0] timer_sig_in, // routed timer inputs
    output wire [NT-1:0] timer_sig_out, // routed timer outputs
    output wire [NT-1:0] timer_pad_drive_en, // pad enable, low while driving
    output wire [NT-1:0] timer_irq_o // interrupt per timer, level
);

    reg [NT-1:0] on_reg; // timer_on_set state
    reg [NT-1:0] ovf_reg; // overflow_error_flag
    reg [NT-1:0] irq_reg; // timer_irq_latch

    wire stat_wr = wr_i && (addr_i == `PTT_ADDR_STAT);

    function [1:0] tsel; // decode of timer index, 3 means none
        input [7:0] a;
        begin
            case (a[7:4])
                4'h1: tsel = 2'h0;
                4'h2: tsel = 2'h1;
                4'h3: tsel = 2'h2;
                default: tsel = 2'h3;
            endcase
        end
    endfunction

    wire [1:0] wsel = tsel(addr_i);
    wire [3:0] wofs = addr_i[3:0];

    reg [31:0] rd_mux;
    reg [31:0] ctl_q [0:NT-1];
    reg [31:0] cnt_q [0:NT-1];
    reg [31:0] prd_q [0:NT-1];
    reg [31:0] wid_q [0:NT-1];

    genvar g;
    generate
        for (g = 0; g < NT; g = g + 1) begin : gt
            reg [31:0] ctl_reg;
            reg [31:0] cnt_reg;
            reg [31:0] prd_reg; // active period, also capture result
            reg [31:0] wid_reg;
            reg [31:0] prd_buf_reg;
            reg [31:0] wid_buf_reg;
            reg pend_reg; // buffered pair waiting for period end
            reg [1:0] dly_reg; // start delay counter
            reg run_reg;
            reg half_reg; // divide-by-two phase
            reg out_reg;
            reg in_s1_reg;
            reg in_s2_reg;
            reg in_d_reg;
            reg irq_set;
            reg ovf_set;
            wire [1:0] mode = ctl_reg[1:0];
            wire pulse = ctl_reg[`PTT_CTL_PULSE];
            wire period_count_select = ctl_reg[`PTT_CTL_PERIOD_COUNT_SELECT];
            wire interrupt_enable = ctl_reg[`PTT_CTL_INTERRUPT_ENABLE];
            wire sel = (wsel == g);
            wire en_w = stat_wr && wdata_i[`PTT_STAT_ON_LO + g];
            wire dis_w = stat_wr && wdata_i[`PTT_STAT_OFF_LO + g];
            wire starting = on_reg[g] && !run_reg && (dly_reg == `PTT_START_DELAY - 1);
            // active-level input: capture measures the chosen level
            wire in_act = (in_s2_reg == pulse);
            wire rise_act = in_act && (in_d_reg != pulse);
            wire evt_rise = in_s2_reg && !in_d_reg;
            wire [31:0] pv = prd_buf_reg & `PTT_VAL_MASK;
            wire [31:0] wv = wid_buf_reg & `PTT_VAL_MASK;
            wire pwm_bad = (wv == 32'h0) || (pv <= wv);
            wire tick = half_reg; // one count every two clocks
            // register write decode for this timer's block
            wire wr_ctl = wr_i && sel && ({4'h0, wofs} == `PTT_OFS_CTL);
            wire wr_prd = wr_i && sel && ({4'h0, wofs} == `PTT_OFS_PRD);
            wire wr_wid = wr_i && sel && ({4'h0, wofs} == `PTT_OFS_WID);

            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    in_s1_reg <= 1'b0;
                    in_s2_reg <= 1'b0;
                    in_d_reg <= 1'b0;
                end else if (mode == `PTT_MODE_CAP || mode == `PTT_MODE_EVT) begin
                    in_s1_reg <= timer_sig_in[g];
                    in_s2_reg <= in_s1_reg;
                    in_d_reg <= in_s2_reg;
                end
            end

            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    ctl_reg <= 32'h0;
                    cnt_reg <= 32'h0;
                    prd_reg <= 32'h0;
                    wid_reg <= 32'h0;
                    prd_buf_reg <= 32'h0;
                    wid_buf_reg <= 32'h0;
                    pend_reg <= 1'b0;
                    dly_reg <= 2'h0;
                    run_reg <= 1'b0;
                    half_reg <= 1'b0;
                    out_reg <= 1'b0;
                    irq_set <= 1'b0;
                    ovf_set <= 1'b0;
                end else begin
                    irq_set <= 1'b0;
                    ovf_set <= 1'b0;
                    // mode changes only while stopped
                    if (wr_ctl && !on_reg[g]) begin
                        ctl_reg <= wdata_i & `PTT_CTL_MASK;
                    end
                    // capture mode leaves period/width read-only
                    if (wr_prd && mode != `PTT_MODE_CAP) begin
                        prd_buf_reg <= wdata_i;
                    end
                    if (wr_wid && mode == `PTT_MODE_PWM) begin
                        wid_buf_reg <= wdata_i;
                        pend_reg <= 1'b1; // width written last arms the pair
                    end
                    if (!on_reg[g] || dis_w) begin
                        run_reg <= 1'b0; // count held
                        dly_reg <= 2'h0;
                        half_reg <= 1'b0;
                        out_reg <= 1'b0;
                        // idle timer mirrors the buffers for read back
                        if (!run_reg) begin
                            prd_reg <= pv;
                            wid_reg <= wv;
                        end
                    end else if (!run_reg) begin
                        // start delay counted from the enable write
                        if (dly_reg != `PTT_START_DELAY - 1) begin
                            dly_reg <= dly_reg + 2'h1;
                        end
                        if (starting) begin
                            half_reg <= 1'b0;
                            pend_reg <= 1'b0;
                            prd_reg <= pv;
                            wid_reg <= wv;
                            case (mode)
                                `PTT_MODE_PWM: begin
                                    if (pwm_bad) begin
                                        ovf_set <= 1'b1;
                                        irq_set <= 1'b1;
                                        dly_reg <= 2'h0;
                                    end else begin
                                        run_reg <= 1'b1;
                                        cnt_reg <= `PTT_ALL_ONES - wv;
                                        out_reg <= 1'b1;
                                    end
                                end
                                `PTT_MODE_CAP: begin
                                    run_reg <= 1'b1;
                                    cnt_reg <= 32'h0;
                                end
                                `PTT_MODE_EVT: begin
                                    run_reg <= 1'b1;
                                    cnt_reg <= pv;
                                end
                                default: dly_reg <= 2'h0;
                            endcase
                        end
                    end else begin
                        half_reg <= !half_reg;
                        case (mode)
                            `PTT_MODE_PWM: if (tick) begin
                                // counter stops one short of all ones
                                if (cnt_reg == `PTT_ALL_ONES - 32'h1) begin
                                    if (out_reg) begin // width expired
                                        out_reg <= 1'b0;
                                        cnt_reg <= `PTT_ALL_ONES - (prd_reg - wid_reg);
                                        if (interrupt_enable && !period_count_select) begin
                                            irq_set <= 1'b1;
                                        end
                                    end else begin // period end: reload pair
                                        out_reg <= period_count_select;
                                        if (interrupt_enable && period_count_select) begin
                                            irq_set <= 1'b1;
                                        end
                                        // single pulse: run drops at period end, but the still-set enable restarts it the next clock
                                        if (!period_count_select) begin
                                            run_reg <= 1'b0;
                                        end
                                        // a bad buffered pair is dropped, old pair kept
                                        if (pend_reg && !pwm_bad) begin
                                            prd_reg <= pv;
                                            wid_reg <= wv;
                                            cnt_reg <= `PTT_ALL_ONES - wv;
                                        end else begin
                                            cnt_reg <= `PTT_ALL_ONES - wid_reg;
                                        end
                                        pend_reg <= 1'b0;
                                    end
                                end else begin
                                    cnt_reg <= cnt_reg + 32'h1;
                                end
                            end
                            `PTT_MODE_CAP: begin
                                // counts every clock, results in units of two
                                cnt_reg <= cnt_reg + 32'h1;
                                if (cnt_reg == `PTT_ALL_ONES) begin
                                    ovf_set <= 1'b1; // wrap is an error
                                    irq_set <= 1'b1;
                                end
                                if (in_d_reg == pulse && !in_act) begin
                                    wid_reg <= cnt_reg >> 1;
                                end
                                if (rise_act) begin
                                    prd_reg <= cnt_reg >> 1;
                                    cnt_reg <= 32'h1;
                                    if (interrupt_enable && period_count_select) begin
                                        irq_set <= 1'b1;
                                    end
                                end
                                if (in_d_reg == pulse && !in_act && interrupt_enable && !period_count_select) begin
                                    irq_set <= 1'b1;
                                end
                            end
                            `PTT_MODE_EVT: if (evt_rise) begin
                                // period plus one events between interrupts
                                if (cnt_reg == 32'h0) begin
                                    cnt_reg <= pv; // buffered period taken here
                                    if (interrupt_enable) begin
                                        irq_set <= 1'b1;
                                    end
                                end else begin
                                    cnt_reg <= cnt_reg - 32'h1;
                                end
                            end
                            default: run_reg <= 1'b0;
                        endcase
                    end
                end
            end

            assign timer_sig_out[g] = (mode == `PTT_MODE_PWM) ? (out_reg ~^ pulse) : 1'b0;
            assign timer_pad_drive_en[g] = !(mode == `PTT_MODE_PWM);
            always @* begin
                ctl_q[g] = ctl_reg;
                cnt_q[g] = cnt_reg;
                prd_q[g] = prd_reg;
                wid_q[g] = wid_reg;
            end

            // global status bits, irq and overflow set beats clear
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    on_reg[g] <= 1'b0;
                    ovf_reg[g] <= 1'b0;
                    irq_reg[g] <= 1'b0;
                end else begin
                    // disable wins over enable in one write
                    if (dis_w) begin
                        on_reg[g] <= 1'b0;
                    end else if (en_w) begin
                        on_reg[g] <= 1'b1;
                    end else if (starting && mode == `PTT_MODE_PWM && pwm_bad) begin
                        // refused start drops the enable
                        on_reg[g] <= 1'b0;
                    end
                    if (ovf_set) begin
                        ovf_reg[g] <= 1'b1;
                    end else if (stat_wr && wdata_i[`PTT_STAT_OVF_LO + g]) begin
                        ovf_reg[g] <= 1'b0;
                    end
                    if (irq_set) begin
                        irq_reg[g] <= 1'b1;
                    end else if (stat_wr && wdata_i[`PTT_STAT_IRQ_LO + g]) begin
                        irq_reg[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign timer_irq_o = irq_reg;

    always @* begin
        rd_mux = 32'h0;
        if (addr_i == `PTT_ADDR_STAT) begin
            rd_mux[`PTT_STAT_IRQ_LO +: NT] = irq_reg;
            rd_mux[`PTT_STAT_OVF_LO +: NT] = ovf_reg;
            rd_mux[`PTT_STAT_ON_LO +: NT] = on_reg;
        end else if (wsel != 2'h3) begin
            case (wofs)
                4'h0: rd_mux = ctl_q[wsel];
                4'h4: rd_mux = cnt_q[wsel]; // valid only while disabled
                4'h8: rd_mux = prd_q[wsel];
                4'hc: rd_mux = wid_q[wsel];
                default: rd_mux = 32'h0;
            endcase
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        // data stands one cycle only, zero otherwise
        if (!rst_n_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            rdata_o <= rd_mux;
        end else begin
            rdata_o <= 32'h0;
        end
    end

endmodule // ptt_timer_trio
`default_nettype wire

// ### dv/ptt_timer_trio_asserts.sv
// port-level checker for the three-timer block
// assumes it is bound onto ptt_timer_trio and shares its timer count
`timescale 1ns/1ps
`default_nettype none
module ptt_chk #(
    parameter NT = 3
) (
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset, active low
    input wire logic [7:0] addr_i, // byte address
    input wire logic [31:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    input wire logic [31:0] rdata_o, // read data
    input wire logic [NT-1:0] timer_sig_out, // timer outputs
    input wire logic [NT-1:0] timer_pad_drive_en, // pad enables, low drives
    input wire logic [NT-1:0] timer_irq_o // interrupt lines
);
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_n_i);
sequence s_en0; wr_i && addr_i == 8'h00 && wdata_i[8] && !wdata_i[12]; endsequence
sequence s_dis0; wr_i && addr_i == 8'h00 && wdata_i[12]; endsequence
sequence s_stat_rd; rd_i && addr_i == 8'h00; endsequence
property p_rd_idle; !rd_i |=> rdata_o == 32'h0; endproperty
a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
property p_pad_sig; (timer_sig_out & timer_pad_drive_en) == '0; endproperty
a_pad_sig: assert property (p_pad_sig) else $error("output active while pad released");
property p_pad_wr; !$stable(timer_pad_drive_en) |-> $past(wr_i); endproperty
a_pad_wr: assert property (p_pad_wr) else $error("pad enable moved without a write");
property p_irq_fall; |($past(timer_irq_o) & ~timer_irq_o) |-> $past(wr_i && addr_i == 8'h00); endproperty
a_irq_fall: assert property (p_irq_fall) else $error("interrupt cleared without a write");
property p_stat_irq; s_stat_rd |=> rdata_o[NT-1:0] == $past(timer_irq_o); endproperty
a_stat_irq: assert property (p_stat_irq) else $error("status read disagrees with irq lines");
property p_dis_now; s_dis0 ##1 s_stat_rd |=> !rdata_o[8]; endproperty
a_dis_now: assert property (p_dis_now) else $error("timer still enabled after disable");
property p_en_now; s_en0 ##1 s_stat_rd |=> rdata_o[8]; endproperty
a_en_now: assert property (p_en_now) else $error("enable bit not set after write");
property p_bit31; rd_i && addr_i[7:4] != 4'h0 && addr_i[3] |=> !rdata_o[31]; endproperty
a_bit31: assert property (p_bit31) else $error("period or width bit 31 kept");
endmodule // ptt_chk
bind ptt_timer_trio ptt_chk #(.NT(NT)) i_ptt_chk (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .timer_sig_out, .timer_pad_drive_en, .timer_irq_o);
`default_nettype wire

// ### dv/ptt_partner.sv
// far-side model of the routed timer pins
// assumes pad enable low while the timer drives the shared pin
`timescale 1ns/1ps
`default_nettype none
module ptt_partner #(
    parameter NT = 3
) (
    input wire logic clk_i, // clock
    input wire logic [NT-1:0] timer_sig_out, // timer outputs
    input wire logic [NT-1:0] timer_pad_drive_en, // pad enables, low drives
    output logic [NT-1:0] timer_sig_in // resolved pin level
);
logic [NT-1:0] ext_reg = '0;
// pin follows the timer while it drives, else this model
assign timer_sig_in = (timer_pad_drive_en & ext_reg) | (~timer_pad_drive_en & timer_sig_out);
task pulse(input int n, input int hi, input int lo);
    ext_reg[n] <= 1'b1;
    repeat (hi) @(posedge clk_i);
    ext_reg[n] <= 1'b0;
    repeat (lo) @(posedge clk_i);
endtask
endmodule // ptt_partner
`default_nettype wire

// ### dv/test_ptt_timer_trio.sv
// self-checking bench for the three-timer block
// assumes the partner model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module test_ptt_timer_trio;
logic clk_i = 1'b0;
logic rst_n_i = 1'b0;
logic [7:0] addr_i = 8'h00;
logic [31:0] wdata_i = 32'h0;
logic wr_i = 1'b0;
logic rd_i = 1'b0;
logic rd_d = 1'b0;
logic [31:0] lfsr = 32'hf2d89131;
logic [63:0] exp_q[$];
wire [31:0] rdata_o;
wire [2:0] timer_sig_in;
wire [2:0] timer_sig_out;
wire [2:0] timer_pad_drive_en;
wire [2:0] timer_irq_o;
int miscompares = 0;
int num_checks = 0;
int cycles = 0;
int n;
always #5 clk_i = ~clk_i;
ptt_timer_trio i_ptt_timer_trio (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .timer_sig_in, .timer_sig_out, .timer_pad_drive_en, .timer_irq_o);
ptt_partner i_ptt_partner (.clk_i, .timer_sig_out, .timer_pad_drive_en, .timer_sig_in);
function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
task chk(input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
        miscompares++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
endtask
task conclude;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask
task bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
endtask
task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    bus(1'b0, 1'b1, a, 32'h0);
endtask
task idle(input int k);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (k) @(posedge clk_i);
endtask
task meas(input int i, input logic lv, output int c);
    c = 0;
    while (timer_sig_out[i] === lv && c < 100) begin
        @(negedge clk_i);
        c++;
    end
endtask
// read results are compared one cycle after their strobe
always @(posedge clk_i) begin
    rd_d <= rd_i;
    cycles <= cycles + 1;
    if (rd_d) begin
        chk(rdata_o & exp_q[0][63:32], exp_q[0][31:0]);
        void'(exp_q.pop_front());
    end
    if (cycles == 20000) begin
        miscompares++;
        conclude();
    end
end
initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk(32'(timer_pad_drive_en), 32'h7);
    for (int m = 0; m < 4; m++) begin
        wr(8'h10, 32'(m));
        rd(8'h10, 32'(m), 32'hffffffff);
        idle(1);
        chk(32'(timer_pad_drive_en[0]), 32'(m != 1));
    end
    lfsr = nxt(lfsr);
    wr(8'h10, 32'h6);
    wr(8'h18, lfsr);
    rd(8'h18, 32'h0, 32'hffffffff);
    wr(8'h00, 32'h100);
    rd(8'h00, 32'h100, 32'h700);
    idle(2);
    i_ptt_partner.pulse(0, 20, 10);
    rd(8'h1c, 32'h8, 32'hfffffffc);
    wr(8'h00, 32'h1100);
    rd(8'h00, 32'h0, 32'h700);
    wr(8'h20, 32'h1d);
    wr(8'h28, {lfsr[31], 31'h4});
    wr(8'h2c, {~lfsr[31], 31'h1});
    rd(8'h28, 32'h4, 32'hffffffff);
    wr(8'h00, 32'h200);
    idle(0);
    meas(1, 1'b0, n);
    chk(32'(n >= 3 && n <= 5), 32'h1);
    meas(1, 1'b1, n);
    chk(n, 32'h2);
    meas(1, 1'b0, n);
    chk(n, 32'h6);
    @(posedge clk_i);
    wr(8'h28, 32'h6);
    wr(8'h2c, 32'h2);
    rd(8'h28, 32'h4, 32'hffffffff);
    idle(0);
    meas(1, 1'b1, n);
    meas(1, 1'b0, n);
    meas(1, 1'b1, n);
    chk(n, 32'h4);
    meas(1, 1'b0, n);
    chk(n, 32'h8);
    chk(32'(timer_irq_o[1]), 32'h1);
    @(posedge clk_i);
    wr(8'h00, 32'h2000);
    rd(8'h00, 32'h2, 32'h702);
    idle(0);
    @(negedge clk_i);
    n = 32'(timer_sig_out[1]);
    repeat (10) @(negedge clk_i);
    chk(32'(timer_sig_out[1]), n);
    @(posedge clk_i);
    lfsr = nxt(lfsr);
    wr(8'h30, 32'h15);
    wr(8'h38, 32'h4);
    wr(8'h3c, 32'h4 + 32'(lfsr[2:0]));
    wr(8'h00, 32'h400);
    idle(8);
    rd(8'h00, 32'h46, 32'h777);
    rd(8'h34, 32'h0, 32'hffffffff);
    wr(8'h00, 32'h46);
    rd(8'h00, 32'h0, 32'h777);
    wr(8'h30, 32'h13);
    wr(8'h38, 32'h3);
    wr(8'h00, 32'h400);
    idle(2);
    repeat (3) i_ptt_partner.pulse(2, 4, 4);
    chk(32'(timer_irq_o[2]), 32'h0);
    i_ptt_partner.pulse(2, 4, 4);
    repeat (4) @(posedge clk_i);
    chk(32'(timer_irq_o[2]), 32'h1);
    conclude();
end
endmodule // test_ptt_timer_trio
`default_nettype wire
